// ===== src/cfs_fault_supervisor.v
// Contract
// RULE1 - With an external ballast, the supply-low flag sets whenever the peripheral supply is below its threshold.
// RULE2 - A supply-low event raises an interrupt when that source is enabled.
// RULE3 - While the supply is flagged low the CAN driver and receiver stay off.
// RULE4 - Without ballast, a main regulator undervoltage drives reset mode and sets the supply-low flag.
// RULE5 - Transmit input held low past the timeout is a stuck fault that disables the driver.
// RULE6 - The driver returns by itself as soon as the transmit input goes high.
// RULE7 - The stuck flag sits at D2 of the CAN status register and clears only on a read after the fault ends.
// RULE8 - A stuck fault also sets the global fault flag and may raise an enabled interrupt.
// RULE9 - Driver overtemperature disables the driver and sets the thermal and global fault flags.
// RULE10 - An enabled thermal interrupt is signalled on an overtemperature event.
// RULE11 - No transmit during overtemperature; the driver returns when the condition ends.
// RULE12 - The thermal flag clears only on a CAN status read after the condition ends.
// RULE13 - Bus overcurrent sets its flag and the global fault flag and may raise an enabled interrupt.
// RULE14 - The overcurrent flag clears only on a CAN status read after the condition ends.
// RULE15 - A serial frame is one byte, MSB first: 3-bit address, read/write bit, 4-bit data.
// RULE16 - The wake flag sets on a bus wake-up and clears only on a read with the CAN in normal mode.
// RULE17 - The interrupt pulses when an enabled flag becomes newly set; disabled sources only update flags.
`timescale 1ns/1ps
`include "cfs_regs.vh"

module cfs_fault_supervisor (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // Serial control port
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_mosi,
  output reg spi_miso_r,
  // Supply monitors
  input wire ballast_used,
  input wire periph_supply_below,
  input wire main_reg_uv,
  // CAN fault and wake inputs
  input wire tx_in,
  input wire drv_overtemp,
  input wire bus_overcurrent,
  input wire bus_wake_event,
  // Control outputs
  output reg can_drv_en_r,
  output reg can_rx_en_r,
  output reg reset_mode_r,
  output reg int_pulse_r,
  output reg global_fault_r
);

  localparam [`CFS_TX_CNT_W-1:0] TX_STUCK_CYC = `CFS_TX_STUCK_CYC;

  // Read nibble of a register
  function [3:0] rd_nib;
    input [2:0] adr;
    input gf;
    input sl;
    input [3:0] canf;
    input [3:0] ien;
    begin
      case (adr)
        `CFS_ADR_MODE: rd_nib = {gf, 3'h0};
        `CFS_ADR_IO: rd_nib = {3'h0, sl};
        `CFS_ADR_CAN: rd_nib = canf;
        `CFS_ADR_INT: rd_nib = ien;
        default: rd_nib = 4'h0;
      endcase
    end
  endfunction

  // Latched flag: a set in the clearing cycle wins
  function latch_nxt;
    input cur;
    input set;
    input clr;
    begin
      latch_nxt = set | (cur & ~clr);
    end
  endfunction

  // Completed frame aimed at one address in one direction
  function frame_hit;
    input done;
    input [2:0] adr;
    input wr;
    input [2:0] want_adr;
    input want_wr;
    begin
      frame_hit = done & (adr == want_adr) & (wr == want_wr);
    end
  endfunction

  // Serial port state
  reg sck_q_r;
  reg cs_q_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [3:0] out_sh_r;
  // Configuration
  reg [3:0] int_en_r;
  reg can_sleep_r;
  reg wake_en_r;
  // Fault state
  reg [`CFS_TX_CNT_W-1:0] tx_cnt_r;
  reg tx_stuck_r;
  reg sup_low_flag_r;
  reg txs_flag_r;
  reg driver_thermal_flag_flag_r;
  reg ovc_flag_r;
  reg wake_flag_r;
  // Next values
  reg [3:0] int_en_nxt;
  reg can_sleep_nxt;
  reg wake_en_nxt;
  reg [`CFS_TX_CNT_W-1:0] tx_cnt_nxt;
  reg tx_stuck_nxt;
  reg sup_low_flag_nxt;
  reg txs_flag_nxt;
  reg driver_thermal_flag_flag_nxt;
  reg ovc_flag_nxt;
  reg wake_flag_nxt;
  reg global_fault_nxt;
  reg can_drv_en_nxt;
  reg can_rx_en_nxt;
  reg reset_mode_nxt;
  reg int_pulse_nxt;

  wire sck_rise = spi_sck & ~sck_q_r & ~spi_cs_n;
  wire sck_fall = ~spi_sck & sck_q_r & ~spi_cs_n;
  wire frame_end = spi_cs_n & ~cs_q_r & (bit_cnt_r == `CFS_FRAME_BITS);
  wire [2:0] fr_adr = shift_r[`CFS_ADR_HI:`CFS_ADR_LO];
  wire fr_wr = shift_r[`CFS_RW_BIT] == `CFS_RW_WRITE;
  wire [3:0] fr_dat = shift_r[3:0];
  wire rd_io = frame_hit(frame_end, fr_adr, fr_wr, `CFS_ADR_IO, ~`CFS_RW_WRITE);
  wire rd_can = frame_hit(frame_end, fr_adr, fr_wr, `CFS_ADR_CAN, ~`CFS_RW_WRITE);
  wire rd_mode = frame_hit(frame_end, fr_adr, fr_wr, `CFS_ADR_MODE, ~`CFS_RW_WRITE);
  wire wr_can = frame_hit(frame_end, fr_adr, fr_wr, `CFS_ADR_CAN, `CFS_RW_WRITE);
  wire wr_int = frame_hit(frame_end, fr_adr, fr_wr, `CFS_ADR_INT, `CFS_RW_WRITE);
  // After the 4th bit the address sits in bits 3..1, read/write in bit 0
  wire [2:0] hdr_adr = shift_r[3:1];

  // Supply conditions: ballast compares its own supply, else main regulator
  wire sup_low_cond = ballast_used ? periph_supply_below : main_reg_uv;
  wire can_fail_cond = tx_stuck_r | drv_overtemp | bus_overcurrent;
  // CAN side off while asleep or while the supply is low or flagged low
  wire can_off = can_sleep_r | sup_low_cond | sup_low_flag_r;

  wire [3:0] can_flags = {wake_flag_r, txs_flag_r, driver_thermal_flag_flag_r, ovc_flag_r};
  // Read nibble of the register named in the header
  wire [3:0] rd_val = rd_nib(hdr_adr, global_fault_r, sup_low_flag_r, can_flags, int_en_r);
  // Wake caught only while asleep with wake enabled; clear needs normal mode
  wire wake_set = bus_wake_event & can_sleep_r & wake_en_r;
  wire wake_clr = rd_can & ~can_sleep_r;

  // Serial frame shifter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      out_sh_r <= 4'h0;
      spi_miso_r <= 1'b0;
    end else if (ce) begin
      sck_q_r <= spi_sck;
      cs_q_r <= spi_cs_n;
      if (spi_cs_n) begin
        bit_cnt_r <= 4'h0;
        spi_miso_r <= 1'b0;
      end else begin
        // RULE15 MSB first shift
        if (sck_rise) begin
          shift_r <= {shift_r[6:0], spi_mosi};
          // Counts on to nine so an overlong frame is refused
          if (bit_cnt_r != `CFS_FRAME_BITS + 4'h1)
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        // Load read nibble once the header is in, then shift it out
        if (sck_fall && bit_cnt_r == `CFS_HDR_BITS) begin
          spi_miso_r <= rd_val[3];
          out_sh_r <= {rd_val[2:0], 1'b0};
        end else if (sck_fall && bit_cnt_r > `CFS_HDR_BITS && bit_cnt_r < `CFS_FRAME_BITS) begin
          spi_miso_r <= out_sh_r[3];
          out_sh_r <= {out_sh_r[2:0], 1'b0};
        end
      end
    end
  end

  // Configuration written over the serial port
  always @* begin
    int_en_nxt = int_en_r;
    can_sleep_nxt = can_sleep_r;
    wake_en_nxt = wake_en_r;
    if (wr_int)
      int_en_nxt = fr_dat;
    if (wr_can) begin
      can_sleep_nxt = fr_dat[`CFS_CAN_SLEEP];
      wake_en_nxt = fr_dat[`CFS_CAN_WAKE_EN];
    end
  end

  // Configuration registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int_en_r <= `CFS_RST_INT_EN;
      can_sleep_r <= `CFS_RST_CAN_SLEEP;
      wake_en_r <= `CFS_RST_WAKE_EN;
    end else if (ce) begin
      int_en_r <= int_en_nxt;
      can_sleep_r <= can_sleep_nxt;
      wake_en_r <= wake_en_nxt;
    end
  end

  // Transmit dominant timeout
  always @* begin
    tx_cnt_nxt = tx_cnt_r;
    tx_stuck_nxt = tx_stuck_r;
    // RULE6 release on high
    if (tx_in) begin
      tx_cnt_nxt = {`CFS_TX_CNT_W{1'b0}};
      tx_stuck_nxt = 1'b0;
    end else if (tx_cnt_r != TX_STUCK_CYC) begin
      tx_cnt_nxt = tx_cnt_r + {{(`CFS_TX_CNT_W-1){1'b0}}, 1'b1};
    end else begin
      // RULE5 timeout reached
      tx_stuck_nxt = 1'b1;
    end
  end

  // Timeout counter and stuck state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_cnt_r <= {`CFS_TX_CNT_W{1'b0}};
      tx_stuck_r <= 1'b0;
    end else if (ce) begin
      tx_cnt_r <= tx_cnt_nxt;
      tx_stuck_r <= tx_stuck_nxt;
    end
  end

  // Next flag values: a set in the clearing cycle wins
  always @* begin
    // RULE1 RULE4 supply low
    sup_low_flag_nxt = latch_nxt(sup_low_flag_r, sup_low_cond, rd_io);
    // RULE7 stuck flag
    txs_flag_nxt = latch_nxt(txs_flag_r, tx_stuck_r, rd_can);
    // RULE9 RULE12 thermal flag
    driver_thermal_flag_flag_nxt = latch_nxt(driver_thermal_flag_flag_r, drv_overtemp, rd_can);
    // RULE13 RULE14 overcurrent flag
    ovc_flag_nxt = latch_nxt(ovc_flag_r, bus_overcurrent, rd_can);
    // RULE16 wake flag
    wake_flag_nxt = latch_nxt(wake_flag_r, wake_set, wake_clr);
    // RULE8 RULE9 RULE13 global fault
    global_fault_nxt = latch_nxt(global_fault_r, can_fail_cond, rd_mode);
  end

  // Latched flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_low_flag_r <= 1'b0;
      txs_flag_r <= 1'b0;
      driver_thermal_flag_flag_r <= 1'b0;
      ovc_flag_r <= 1'b0;
      wake_flag_r <= 1'b0;
      global_fault_r <= 1'b0;
    end else if (ce) begin
      sup_low_flag_r <= sup_low_flag_nxt;
      txs_flag_r <= txs_flag_nxt;
      driver_thermal_flag_flag_r <= driver_thermal_flag_flag_nxt;
      ovc_flag_r <= ovc_flag_nxt;
      wake_flag_r <= wake_flag_nxt;
      global_fault_r <= global_fault_nxt;
    end
  end

  // Sources whose flag is about to rise
  wire [3:0] new_set = {bus_overcurrent & ~ovc_flag_r, drv_overtemp & ~driver_thermal_flag_flag_r,
                        tx_stuck_r & ~txs_flag_r, sup_low_cond & ~sup_low_flag_r};

  // Next driver, receiver, reset mode and interrupt
  always @* begin
    // RULE3 RULE5 RULE9 RULE11 driver gating
    can_drv_en_nxt = ~can_off & ~tx_stuck_r & ~drv_overtemp;
    // RULE3 receiver gating
    can_rx_en_nxt = ~can_off;
    // RULE4 reset mode
    reset_mode_nxt = ~ballast_used & main_reg_uv;
    // RULE2 RULE10 RULE17 masked pulse
    int_pulse_nxt = |(new_set & int_en_r);
  end

  // Driver, receiver, reset mode and interrupt outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      can_drv_en_r <= 1'b0;
      can_rx_en_r <= 1'b0;
      reset_mode_r <= 1'b0;
      int_pulse_r <= 1'b0;
    end else if (ce) begin
      can_drv_en_r <= can_drv_en_nxt;
      can_rx_en_r <= can_rx_en_nxt;
      reset_mode_r <= reset_mode_nxt;
      int_pulse_r <= int_pulse_nxt;
    end
  end

endmodule // cfs_fault_supervisor

// ===== src/cfs_regs.vh
`ifndef CFS_REGS_VH
`define CFS_REGS_VH
// Clock and transmit-stuck timeout
`define CFS_CLK_PERIOD_NS 100
`define CFS_TX_STUCK_NS 360000
// 360000 ns over the 100 ns period is 3600 clocks
`define CFS_TX_STUCK_CYC 12'hE10
`define CFS_TX_CNT_W 12
// Serial frame layout, MSB first
`define CFS_FRAME_BITS 4'h8
`define CFS_HDR_BITS 4'h4
`define CFS_ADR_HI 7
`define CFS_ADR_LO 5
`define CFS_RW_BIT 4
`define CFS_RW_WRITE 1'b1
// Register addresses
`define CFS_ADR_MODE 3'h0
`define CFS_ADR_IO 3'h1
`define CFS_ADR_CAN 3'h2
`define CFS_ADR_INT 3'h3
// Mode control register fields
`define CFS_MODE_GFAULT 3
// I/O status register fields
`define CFS_IO_SUPLOW 0
// CAN status register fields (read) and control (write)
`define CFS_CAN_WAKE 3
`define CFS_CAN_TXSTUCK 2
`define CFS_CAN_DRIVER_THERMAL_FLAG 1
`define CFS_CAN_OVCUR 0
`define CFS_CAN_SLEEP 0
`define CFS_CAN_WAKE_EN 1
// Interrupt enable register fields
`define CFS_INT_SUPLOW 0
`define CFS_INT_TXSTUCK 1
`define CFS_INT_DRIVER_THERMAL_FLAG 2
`define CFS_INT_OVCUR 3
// Reset values
`define CFS_RST_INT_EN 4'h0
`define CFS_RST_CAN_SLEEP 1'b0
`define CFS_RST_WAKE_EN 1'b0
`endif

// ===== testbench/cfs_fault_supervisor_monitor.sv
`timescale 1ns/1ps
module cfs_monitor (
  // Clock and reset
  input logic clk, rst, ce,
  // Watched inputs
  input logic spi_cs_n, ballast_used, periph_supply_below, main_reg_uv, tx_in, drv_overtemp, bus_overcurrent,
  // Watched outputs
  input logic spi_miso_r, can_drv_en_r, can_rx_en_r, reset_mode_r, int_pulse_r, global_fault_r
);
  logic [12:0] low_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Consecutive dominant cycles, saturating
  always_ff @(posedge clk or posedge rst)
    if (rst) low_r <= 13'h0;
    else if (ce) low_r <= tx_in ? 13'h0 : low_r + {12'h0, ~&low_r};
  // Properties
  property p_stuck_drv; low_r == 13'hE74 |-> !can_drv_en_r; endproperty
  property p_stuck_gf; low_r == 13'hE74 |-> global_fault_r; endproperty
  property p_supply_off; ce && ballast_used && periph_supply_below |=> !can_drv_en_r && !can_rx_en_r; endproperty
  property p_uv_reset; ce && !ballast_used && main_reg_uv |=> reset_mode_r; endproperty
  property p_hot; ce && drv_overtemp |=> !can_drv_en_r && global_fault_r; endproperty
  property p_ovc; ce && bus_overcurrent |=> global_fault_r; endproperty
  property p_gf_clear;
    $fell(global_fault_r) |-> !($past(spi_cs_n, 2) && $past(spi_cs_n, 3) && $past(spi_cs_n, 4) && $past(spi_cs_n, 5));
  endproperty
  property p_miso_idle; spi_cs_n [*3] |-> !spi_miso_r; endproperty
  property p_int_one; int_pulse_r |=> !int_pulse_r; endproperty
  a_stuck_drv: assert property (p_stuck_drv) else $error("driver on after stuck timeout");
  a_stuck_gf: assert property (p_stuck_gf) else $error("no global fault on stuck");
  a_supply_off: assert property (p_supply_off) else $error("can active on low supply");
  a_uv_reset: assert property (p_uv_reset) else $error("no reset mode on undervoltage");
  a_hot: assert property (p_hot) else $error("overtemperature not handled");
  a_ovc: assert property (p_ovc) else $error("no global fault on overcurrent");
  a_gf_clear: assert property (p_gf_clear) else $error("global fault cleared without read");
  a_miso_idle: assert property (p_miso_idle) else $error("miso busy outside frame");
  a_int_one: assert property (p_int_one) else $error("interrupt longer than one cycle");
  // Main scenarios reached
  c_stuck: cover property (low_r == 13'hE74);
  c_int: cover property (int_pulse_r);
  c_gf_clear: cover property ($fell(global_fault_r));
endmodule // cfs_monitor
bind cfs_fault_supervisor cfs_monitor i_cfs_monitor (.*);

// ===== testbench/cfs_mcu_model.sv
`timescale 1ns/1ps
module cfs_mcu_model (
  // Clock
  input logic clk,
  // Serial lines
  output logic spi_cs_n = 1'b1,
  output logic spi_sck = 1'b0,
  output logic spi_mosi = 1'b0,
  input logic spi_miso_r
);
  // one byte, MSB first, read data just before the last four rises
  task automatic xfer(input logic [7:0] b, output logic [3:0] d);
    int i;
    @(posedge clk) spi_cs_n <= 1'b0;
    // Clock low and high two clocks each; data held across the rise
    for (i = 7; i >= 0; i--) begin
      spi_mosi <= b[i];
      repeat (2) @(posedge clk);
      if (i < 4) d[i] = spi_miso_r;
      spi_sck <= 1'b1;
      repeat (2) @(posedge clk);
      spi_sck <= 1'b0;
    end
    // Let the last fall be seen before the frame closes
    repeat (2) @(posedge clk);
    spi_cs_n <= 1'b1;
    // Released data line no longer shows the last bit
    spi_mosi <= ~spi_mosi;
    repeat (4) @(posedge clk);
  endtask
endmodule // cfs_mcu_model

// ===== testbench/cfs_fault_supervisor_tb.sv
`timescale 1ns/1ps
module cfs_fault_supervisor_tb;
  logic clk = 1'b0, rst = 1'b1, ballast_used = 1'b1, periph_supply_below = 1'b0, main_reg_uv = 1'b0, tx_in = 1'b1;
  logic drv_overtemp = 1'b0, bus_overcurrent = 1'b0, bus_wake_event = 1'b0, spi_cs_n, spi_sck, spi_mosi;
  logic spi_miso_r, can_drv_en_r, can_rx_en_r, reset_mode_r, int_pulse_r, global_fault_r;
  logic [3:0] rd;
  logic ce = 1'b1;
  int bad_count = 0;
  int check_count = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  // Device and serial master
  cfs_fault_supervisor i_cfs_fault_supervisor (.*);
  cfs_mcu_model i_cfs_mcu_model (.*);
  // Compare and count
  task automatic chk(input string n, input logic [3:0] s, input logic [3:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // Register access over the serial port
  task automatic rd_reg(input logic [2:0] a, input logic [3:0] e, input string n);
    i_cfs_mcu_model.xfer({a, 1'b0, 4'h0}, rd);
    chk(n, rd, e);
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [3:0] v);
    i_cfs_mcu_model.xfer({a, 1'b1, v}, rd);
  endtask
  // Thermal or overcurrent fault, set then removed
  task automatic flt(input logic [1:0] f, input logic ie);
    @(posedge clk) {drv_overtemp, bus_overcurrent} <= f;
    @(posedge clk) #1;
    chk("int", 4'(int_pulse_r), 4'(ie));
    chk("drv_en", 4'(can_drv_en_r), 4'(!f[1]));
    chk("gfault", 4'(global_fault_r), 4'h1);
    rd_reg(3'h2, {2'h0, f}, "can_st");
    rd_reg(3'h2, {2'h0, f}, "can_st");
    @(posedge clk) {drv_overtemp, bus_overcurrent} <= 2'h0;
    repeat (2) @(posedge clk);
    #1 chk("drv_en", 4'(can_drv_en_r), 4'h1);
    rd_reg(3'h2, {2'h0, f}, "can_st");
    rd_reg(3'h2, 4'h0, "can_st");
    rd_reg(3'h0, 4'h8, "mode");
    rd_reg(3'h0, 4'h0, "mode");
  endtask
  // Verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog, about four times the expected run
  initial begin
    #2ms;
    bad_count++;
    end_sim();
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(3'h3, 4'h0, "int_en");
    rd_reg(3'h5, 4'h0, "unmapped");
    wr_reg(3'h3, 4'hF);
    rd_reg(3'h3, 4'hF, "int_en");
    flt(2'b10, 1'b1);
    flt(2'b01, 1'b1);
    wr_reg(3'h3, 4'h0);
    flt(2'b10, 1'b0);
    // Clock enable low freezes every flag
    @(posedge clk) ce <= 1'b0;
    @(posedge clk) bus_overcurrent <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("gfault", 4'(global_fault_r), 4'h0);
    @(posedge clk) bus_overcurrent <= 1'b0;
    @(posedge clk) ce <= 1'b1;
    rd_reg(3'h2, 4'h0, "can_st");
    $display("test faults done");
    wr_reg(3'h3, 4'h2);
    @(posedge clk) tx_in <= 1'b0;
    repeat (3590) @(posedge clk);
    #1 chk("drv_en", 4'(can_drv_en_r), 4'h1);
    repeat (20) @(posedge clk);
    #1 chk("drv_en", 4'(can_drv_en_r), 4'h0);
    chk("gfault", 4'(global_fault_r), 4'h1);
    rd_reg(3'h2, 4'h4, "can_st");
    @(posedge clk) tx_in <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("drv_en", 4'(can_drv_en_r), 4'h1);
    rd_reg(3'h2, 4'h4, "can_st");
    rd_reg(3'h2, 4'h0, "can_st");
    $display("test stuck done");
    wr_reg(3'h3, 4'h1);
    @(posedge clk) periph_supply_below <= 1'b1;
    @(posedge clk) #1;
    chk("int", 4'(int_pulse_r), 4'h1);
    chk("rx_en", 4'(can_rx_en_r), 4'h0);
    @(posedge clk) periph_supply_below <= 1'b0;
    rd_reg(3'h1, 4'h1, "io");
    rd_reg(3'h1, 4'h0, "io");
    @(posedge clk) ballast_used <= 1'b0;
    @(posedge clk) main_reg_uv <= 1'b1;
    @(posedge clk) #1;
    chk("rst_mode", 4'(reset_mode_r), 4'h1);
    @(posedge clk) main_reg_uv <= 1'b0;
    rd_reg(3'h1, 4'h1, "io");
    rd_reg(3'h1, 4'h0, "io");
    @(posedge clk) ballast_used <= 1'b1;
    $display("test supply done");
    wr_reg(3'h2, 4'h3);
    @(posedge clk) bus_wake_event <= 1'b1;
    @(posedge clk) bus_wake_event <= 1'b0;
    rd_reg(3'h2, 4'h8, "can_st");
    rd_reg(3'h2, 4'h8, "can_st");
    wr_reg(3'h2, 4'h0);
    rd_reg(3'h2, 4'h8, "can_st");
    rd_reg(3'h2, 4'h0, "can_st");
    $display("test wake done");
    end_sim();
  end
endmodule // cfs_fault_supervisor_tb
